/* File: rtcb_alarm_cmp.sv */
// one alarm comparator with a mask bit per calendar field
// assumes time and date words in the register layout of the main block
module rtcb_alarm_cmp (
    // current calendar
    input  wire logic [31:0] time_w,
    input  wire logic [31:0] date_w,
    input  wire logic [12:0] subsec,
    // alarm setting
    input  wire logic [31:0] alrm,
    input  wire logic [31:0] alss,
    // result
    output logic             match
);
    import rtcb_pkg::*;

    logic s_ok, m_ok, h_ok, d_ok, ss_ok;

    // a masked field always matches
    assign s_ok  = alrm[AL_MSK_S] || alrm[6:0] == time_w[6:0];
    assign m_ok  = alrm[AL_MSK_M] || alrm[14:8] == time_w[14:8];
    assign h_ok  = alrm[AL_MSK_H] || alrm[22:16] == time_w[22:16];
    assign d_ok  = alrm[AL_MSK_D] || (alrm[AL_WDSEL] ? alrm[26:24] == date_w[15:13]
                                                     : alrm[29:24] == date_w[5:0]);
    assign ss_ok = alss[SS_MSK] || alss[12:0] == subsec;
    assign match = s_ok && m_ok && h_ok && d_ok && ss_ok;
endmodule

/* File: rtcb_backup_rtc.sv */
// backup-domain rtc: bcd calendar, two alarms, wakeup timer, backup regs and sram
// assumes source clocks as synchronous one-cycle ticks and a single-cycle register port
//
// Contract
// - keep seconds to year in bcd, hours in 12 or 24 hour form
// - advance date by month length, february 29 days in leap years
// - alarm and periodic events can wake the system
// - current sub-second count readable as plain binary
// - time base from lse, lsi, or hse divided by 128
// - drive a 512 hz calibration output
// - two alarm comparators, every field maskable
// - 16-bit auto-reload wakeup downcounter, selectable resolution, 120 us to 36 h
// - 20-bit prescaler, defaults give one second from 32.768 khz
// - backup sram disabled after reset, usable once software enables it
// - twenty 32-bit backup registers
// - backup registers unchanged by system reset, power reset, standby wakeup
// - alarm targets held in 32-bit registers with sub-second to date
module rtcb_backup_rtc (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        nrst,
    // source clock ticks
    input  wire logic                        lse_tick,
    input  wire logic                        lsi_tick,
    input  wire logic                        hse_tick,
    // register port
    input  wire logic [rtcb_pkg::ADDR_W-1:0] addr,
    input  wire logic [31:0]                 wdata,
    input  wire logic                        we,
    input  wire logic                        re,
    output logic      [31:0]                 rdata,
    // events and pins
    output logic                             irq,
    output logic                             wake,
    output logic                             cal_out
);
    import rtcb_pkg::*;

    typedef struct packed {
        logic [6:0]             sec;
        logic [6:0]             min;
        logic [5:0]             hour;
        logic                   pm;
        logic [5:0]             date;
        logic [4:0]             mon;
        logic [2:0]             wday;
        logic [7:0]             year;
        logic [CTRL_W-1:0]      ctrl;
        logic [6:0]             pda;
        logic [12:0]            pds;
        logic [6:0]             acnt;
        logic [12:0]            scnt;
        logic [15:0]            wut_rl;
        logic [16:0]            wut_cnt;
        logic [3:0]             wdiv;
        logic [6:0]             hdiv;
        logic [4:0]             calcnt;
        logic                   cal;
        logic [NEV-1:0]         stat;
        logic [NEV-1:0]         mask;
        logic [NALRM-1:0][31:0] alrm;
        logic [NALRM-1:0][31:0] alss;
        logic [NALRM-1:0]       mprev;
        logic [NBKP-1:0][31:0]  bkp;
        logic [31:0]            rdata;
        logic                   irq;
        logic                   wake;
    } rtcb_state_t;

    rtcb_state_t       s_reg;
    rtcb_state_t       s_next;
    logic [31:0]       sram_mem [SRAM_WORDS];
    logic [NALRM-1:0]  match;
    logic [31:0]       time_w;
    logic [31:0]       date_w;
    logic [ADDR_W-1:0] wa;
    logic [8:0]        inc_s;
    logic [8:0]        inc_m;
    logic [8:0]        inc_h;
    logic [8:0]        inc_d;
    logic [8:0]        inc_mo;
    logic [8:0]        inc_y;
    logic [7:0]        dim;
    logic [16:0]       wut_ld;
    logic [NEV-1:0]    ev;
    logic              leap;
    logic              fmt12;
    logic              day_c;
    logic              day_go;
    logic              wr_time;
    logic              wr_date;
    logic              sram_sel;
    logic              rtc_tick;
    logic              spre;
    logic              sec_tick;
    logic              wut_ck;
    rtcb_clksel_t      csel;
    rtcb_wures_t       wsel;

    // returns {carry, next}; wraps max to min
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] vmax,
                                           input logic [7:0] vmin);
        logic [8:0] r;
        r = {1'b0, v + 8'h01};
        if (v == vmax) begin
            r = {1'b1, vmin};
        end else if (v[3:0] == 4'h9) begin
            r = {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return r;
    endfunction

    assign wa       = {addr[ADDR_W-1:2], 2'b00};
    assign wr_time  = we && wa == A_TIME;
    assign wr_date  = we && wa == A_DATE;
    assign sram_sel = wa >= A_SRAM;
    assign fmt12    = s_reg.ctrl[C_FMT12];
    assign csel     = rtcb_clksel_t'(s_reg.ctrl[C_CLKSEL +: 2]);
    assign wsel     = rtcb_wures_t'(s_reg.ctrl[C_WUTSEL +: 3]);
    assign time_w   = {9'h000, s_reg.pm, s_reg.hour, 1'b0, s_reg.min, 1'b0, s_reg.sec};
    assign date_w   = {8'h00, s_reg.year, s_reg.wday, s_reg.mon, 2'b00, s_reg.date};

    // leap when the bcd year is a multiple of four
    assign leap = s_reg.year[4] ? (s_reg.year[3:0] == 4'h2 || s_reg.year[3:0] == 4'h6)
                                : (s_reg.year[3:0] == 4'h0 || s_reg.year[3:0] == 4'h4 ||
                                   s_reg.year[3:0] == 4'h8);
    assign dim  = (s_reg.mon == MON_FEB) ? (leap ? FEB_LEAP : FEB_DAYS) :
                  (s_reg.mon == 5'h04 || s_reg.mon == 5'h06 || s_reg.mon == 5'h09 ||
                   s_reg.mon == 5'h11) ? DAYS_SHORT : DAYS_LONG;

    assign inc_s  = bcd_inc({1'b0, s_reg.sec}, SEC_MAX, BCD_ZERO);
    assign inc_m  = bcd_inc({1'b0, s_reg.min}, SEC_MAX, BCD_ZERO);
    assign inc_h  = fmt12 ? bcd_inc({2'b00, s_reg.hour}, HR12_MAX, DAY_MIN)
                          : bcd_inc({2'b00, s_reg.hour}, HR24_MAX, BCD_ZERO);
    assign inc_d  = bcd_inc({2'b00, s_reg.date}, dim, DAY_MIN);
    assign inc_mo = bcd_inc({3'b000, s_reg.mon}, MON_MAX, DAY_MIN);
    assign inc_y  = bcd_inc(s_reg.year, YEAR_MAX, BCD_ZERO);
    // in 12 hour form the day turns at 11 pm to 12 am
    assign day_c  = fmt12 ? (s_reg.hour == HR_PMFLIP[5:0] && s_reg.pm) : inc_h[8];
    assign day_go = sec_tick && inc_s[8] && inc_m[8] && day_c;
    // the extra bit stretches the 1 hz range to twice 65536 s
    assign wut_ld = {wsel == WR_SEC_EXT, s_reg.wut_rl};

    genvar g;
    generate
        for (g = 0; g < NALRM; g++) begin : gen_alarm
            rtcb_alarm_cmp u_cmp (
                .time_w (time_w),
                .date_w (date_w),
                .subsec (s_reg.scnt),
                .alrm   (s_reg.alrm[g]),
                .alss   (s_reg.alss[g]),
                .match  (match[g])
            );
            alarm_set_a: assert property (@(posedge clk) disable iff (!nrst)
                $rose(s_reg.stat[S_ALR + g]) |-> $past(match[g] && s_reg.ctrl[C_ALREN + g]))
                else $error("alarm flag set without an enabled match");
        end
    endgenerate

    always_comb begin
        s_next   = s_reg;
        ev       = '0;
        spre     = 1'b0;
        sec_tick = 1'b0;
        unique case (csel)
            CS_LSE:  rtc_tick = lse_tick;
            CS_LSI:  rtc_tick = lsi_tick;
            CS_HSE:  rtc_tick = hse_tick && s_reg.hdiv == HSE_DIV_LAST;
            default: rtc_tick = 1'b0;
        endcase
        if (hse_tick) begin
            s_next.hdiv = s_reg.hdiv + 7'h01;
        end
        // async stage, then sync stage: 7 + 13 bits of prescale
        if (rtc_tick) begin
            s_next.wdiv   = s_reg.wdiv + 4'h1;
            s_next.calcnt = s_reg.calcnt + 5'h01;
            if (s_reg.calcnt == CAL_LAST) begin
                s_next.cal = ~s_reg.cal;
            end
            if (s_reg.acnt == 7'h00) begin
                s_next.acnt = s_reg.pda;
                spre        = 1'b1;
            end else begin
                s_next.acnt = s_reg.acnt - 7'h01;
            end
        end
        if (!s_reg.ctrl[C_CALEN]) begin
            s_next.cal = 1'b0;
        end
        if (spre) begin
            if (s_reg.scnt == 13'h0000) begin
                s_next.scnt = s_reg.pds;
                sec_tick    = 1'b1;
            end else begin
                s_next.scnt = s_reg.scnt - 13'h0001;
            end
        end
        unique case (wsel)
            WR_DIV16:           wut_ck = rtc_tick && &s_reg.wdiv;
            WR_DIV8:            wut_ck = rtc_tick && &s_reg.wdiv[2:0];
            WR_DIV4:            wut_ck = rtc_tick && &s_reg.wdiv[1:0];
            WR_DIV2:            wut_ck = rtc_tick && s_reg.wdiv[0];
            WR_SEC, WR_SEC_EXT: wut_ck = sec_tick;
            default:            wut_ck = 1'b0;
        endcase
        // disabled counter sits at reload so enabling starts the countdown from the reload value
        if (!s_reg.ctrl[C_WUTEN]) begin
            s_next.wut_cnt = wut_ld;
        end else if (wut_ck) begin
            if (s_reg.wut_cnt == 17'h00000) begin
                s_next.wut_cnt = wut_ld;
                ev[S_WUT]      = wut_ld == 17'h00000;
            end else begin
                s_next.wut_cnt = s_reg.wut_cnt - 17'h00001;
                ev[S_WUT]      = s_reg.wut_cnt == 17'h00001;
            end
        end
        if (sec_tick) begin
            s_next.sec = inc_s[6:0];
            if (inc_s[8]) begin
                s_next.min = inc_m[6:0];
                if (inc_m[8]) begin
                    s_next.hour = inc_h[5:0];
                    if (fmt12 && s_reg.hour == HR_PMFLIP[5:0]) begin
                        s_next.pm = ~s_reg.pm;
                    end
                end
            end
        end
        if (day_go) begin
            s_next.date = inc_d[5:0];
            s_next.wday = (s_reg.wday == WDAY_MAX) ? WDAY_MIN : s_reg.wday + 3'h1;
            if (inc_d[8]) begin
                s_next.mon = inc_mo[4:0];
                if (inc_mo[8]) begin
                    s_next.year = inc_y[7:0];
                end
            end
        end
        // an alarm fires once on the rise of its match
        for (int i = 0; i < NALRM; i++) begin
            ev[S_ALR + i] = s_reg.ctrl[C_ALREN + i] && match[i] && !s_reg.mprev[i];
        end
        s_next.mprev = match;
        if (wr_time) begin
            s_next.sec  = wdata[6:0];
            s_next.min  = wdata[14:8];
            s_next.hour = wdata[21:16];
            s_next.pm   = wdata[22];
            s_next.scnt = s_reg.pds;
            s_next.acnt = s_reg.pda;
        end
        if (wr_date) begin
            s_next.date = wdata[5:0];
            s_next.mon  = wdata[12:8];
            s_next.wday = wdata[15:13];
            s_next.year = wdata[23:16];
        end
        if (we) begin
            unique case (wa)
                A_CTRL:  s_next.ctrl = wdata[CTRL_W-1:0];
                A_PRESC: begin
                    s_next.pds = wdata[12:0];
                    s_next.pda = wdata[22:16];
                end
                A_WUT:   s_next.wut_rl = wdata[15:0];
                A_STAT:  s_next.stat = s_reg.stat & ~wdata[NEV-1:0];
                A_MASK:  s_next.mask = wdata[NEV-1:0];
                default: ;
            endcase
            for (int i = 0; i < NALRM; i++) begin
                if (wa == A_ALRM + ADDR_W'(i) * A_ALRM_STEP) begin
                    s_next.alrm[i] = wdata;
                end
                if (wa == A_ALRM + ADDR_W'(i) * A_ALRM_STEP + A_ALSS_OFS) begin
                    s_next.alss[i] = wdata;
                end
            end
            for (int i = 0; i < NBKP; i++) begin
                if (wa == A_BKP + ADDR_W'(i) * A_BKP_STEP) begin
                    s_next.bkp[i] = wdata;
                end
            end
        end
        // an event in the clearing cycle survives
        s_next.stat  = s_next.stat | ev;
        s_next.rdata = 32'h0000_0000;
        if (re) begin
            unique case (wa)
                A_TIME:  s_next.rdata = time_w;
                A_DATE:  s_next.rdata = date_w;
                A_CTRL:  s_next.rdata = {20'h00000, s_reg.ctrl};
                A_PRESC: s_next.rdata = {9'h000, s_reg.pda, 3'h0, s_reg.pds};
                A_WUT:   s_next.rdata = {16'h0000, s_reg.wut_rl};
                A_SSR:   s_next.rdata = {19'h00000, s_reg.scnt};
                A_STAT:  s_next.rdata = {29'h00000000, s_reg.stat};
                A_MASK:  s_next.rdata = {29'h00000000, s_reg.mask};
                default: ;
            endcase
            for (int i = 0; i < NALRM; i++) begin
                if (wa == A_ALRM + ADDR_W'(i) * A_ALRM_STEP) begin
                    s_next.rdata = s_reg.alrm[i];
                end
                if (wa == A_ALRM + ADDR_W'(i) * A_ALRM_STEP + A_ALSS_OFS) begin
                    s_next.rdata = s_reg.alss[i];
                end
            end
            for (int i = 0; i < NBKP; i++) begin
                if (wa == A_BKP + ADDR_W'(i) * A_BKP_STEP) begin
                    s_next.rdata = s_reg.bkp[i];
                end
            end
            if (sram_sel && s_reg.ctrl[C_SRAMEN]) begin
                s_next.rdata = sram_mem[wa[SRAM_IW+1:2]];
            end
        end
        s_next.irq  = |(s_next.stat & s_next.mask);
        s_next.wake = |(s_next.stat & {s_next.ctrl[C_WUTEN], s_next.ctrl[C_ALREN +: NALRM]});
        if (!nrst) begin
            s_next        = '0;
            s_next.pda    = PDA_RST;
            s_next.pds    = PDS_RST;
            s_next.wut_rl = WUT_RST;
            s_next.acnt   = PDA_RST;
            s_next.scnt   = PDS_RST;
            s_next.date   = DAY_MIN[5:0];
            s_next.mon    = DAY_MIN[4:0];
            s_next.wday   = WDAY_MIN;
            s_next.bkp    = s_reg.bkp;
        end
    end

    always_ff @(posedge clk) begin
        s_reg <= s_next;
    end

    // not reset: contents ride through resets while powered
    always_ff @(posedge clk) begin
        if (nrst && we && sram_sel && s_reg.ctrl[C_SRAMEN]) begin
            sram_mem[wa[SRAM_IW+1:2]] <= wdata;
        end
    end

    assign rdata   = s_reg.rdata;
    assign irq     = s_reg.irq;
    assign wake    = s_reg.wake;
    assign cal_out = s_reg.cal;

    sec_wrap_a: assert property (@(posedge clk) disable iff (!nrst)
        sec_tick && s_reg.sec == SEC_MAX[6:0] && !wr_time
        |=> s_reg.sec == 7'h00 && s_reg.min != $past(s_reg.min))
        else $error("seconds did not wrap with carry");

    feb_end_a: assert property (@(posedge clk) disable iff (!nrst)
        day_go && s_reg.mon == MON_FEB && s_reg.date == FEB_DAYS[5:0] && !wr_date
        |=> s_reg.date == ($past(leap) ? FEB_LEAP[5:0] : DAY_MIN[5:0]))
        else $error("february end handled wrongly");

    wut_reload_a: assert property (@(posedge clk) disable iff (!nrst)
        wut_ck && s_reg.ctrl[C_WUTEN] && s_reg.wut_cnt == 17'h00000 && !we
        |=> s_reg.wut_cnt == $past(wut_ld))
        else $error("wakeup counter did not reload");

    wut_flag_a: assert property (@(posedge clk) disable iff (!nrst)
        wut_ck && s_reg.ctrl[C_WUTEN] && s_reg.wut_cnt == 17'h00001
        |=> s_reg.stat[S_WUT] && s_reg.wut_cnt == 17'h00000)
        else $error("wakeup flag missing at zero");

    wake_out_a: assert property (@(posedge clk) disable iff (!nrst)
        s_reg.stat[S_WUT] && s_reg.ctrl[C_WUTEN] && !we |=> wake)
        else $error("wakeup request not raised");

    sram_off_a: assert property (@(posedge clk) disable iff (!nrst)
        re && sram_sel && !s_reg.ctrl[C_SRAMEN] |=> rdata == 32'h0000_0000)
        else $error("disabled sram returned data");

    bkp_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> $stable(s_reg.bkp))
        else $error("backup registers changed by reset");

    presc_rst_a: assert property (@(posedge clk) disable iff (!nrst)
        $rose(nrst) |-> s_reg.pda == PDA_RST && s_reg.pds == PDS_RST)
        else $error("prescaler default wrong after reset");

    subsec_rd_a: assert property (@(posedge clk) disable iff (!nrst)
        re && wa == A_SSR |=> rdata == {19'h00000, $past(s_reg.scnt)})
        else $error("sub-second read mismatch");

    cal_edge_a: assert property (@(posedge clk) disable iff (!nrst)
        $changed(cal_out) |-> ($past(rtc_tick) && $past(s_reg.calcnt) == CAL_LAST)
                              || !$past(s_reg.ctrl[C_CALEN]))
        else $error("calibration output moved off its tick");
endmodule

/* File: rtcb_backup_rtc_bench.sv */
// bench for the backup-domain rtc: register port, calendar, alarms, wakeup, backup storage
// assumes the block alone on one 50 MHz clock; source ticks are one-cycle strobes made here
module rtcb_backup_rtc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import rtcb_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [2:0]  src_tick = 3'h0;
    logic [12:0] addr = 13'h0000;
    logic [31:0] wdata = 32'h0;
    logic        we = 1'b0;
    logic        re = 1'b0;
    logic [31:0] rdata;
    logic        irq;
    logic        wake;
    logic        cal_out;
    int          error_cnt = 0;
    int          samples_checked = 0;
    // date in, date out across one midnight: leap feb, feb 29, 30-day month, non-leap feb, year end
    localparam logic [31:0] D_IN [5] = '{32'h0024e228, 32'h00242229, 32'h00232430, 32'h0023e228, 32'h0099f231};
    localparam logic [31:0] D_OUT [5] = '{32'h00242229, 32'h00244301, 32'h00234501, 32'h00232301, 32'h00002101};
    // 12 hour: 11am to 12pm, 12pm to 1pm, 11pm to 12am
    localparam logic [31:0] H_IN [3] = '{32'h00115959, 32'h00525959, 32'h00515959};
    localparam logic [31:0] H_OUT [3] = '{32'h00520000, 32'h00410000, 32'h00120000};

    always #10 clk = ~clk;

    rtcb_backup_rtc rtcb_backup_rtc_i (.clk(clk), .nrst(nrst), .lse_tick(src_tick[0]), .lsi_tick(src_tick[1]),
        .hse_tick(src_tick[2]), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
        .irq(irq), .wake(wake), .cal_out(cal_out));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [12:0] a, input logic [31:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rc(input logic [12:0] a, input logic [31:0] exp);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 check(rdata, exp);
    endtask

    // gap between pulses keeps every strobe one cycle wide
    task automatic tk(input int s, input int n);
        repeat (n) begin
            @(posedge clk);
            src_tick[s] <= 1'b1;
            @(posedge clk);
            src_tick[s] <= 1'b0;
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic summarize;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #1ms;
        error_cnt++;
        summarize();
    end

    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rc(A_CTRL, 32'h0);
        rc(A_PRESC, 32'h007f00ff);
        rc(A_WUT, 32'h0000ffff);
        rc(A_SSR, 32'h000000ff);
        rc(A_DATE, 32'h00002101);
        wr(A_SRAM, 32'h5a5a0001);
        rc(A_SRAM, 32'h0);
        wr(A_CTRL, 32'h800);
        wr(A_SRAM, 32'h5a5a0001);
        rc(A_SRAM, 32'h5a5a0001);
        for (int i = 0; i < NBKP; i++) wr(A_BKP + A_BKP_STEP * 13'(i), 32'hb000 + i);
        rc(13'h00a0, 32'h0);
        // mid-run reset must leave backup storage alone
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < NBKP; i++) rc(A_BKP + A_BKP_STEP * 13'(i), 32'hb000 + i);
        rc(A_SRAM, 32'h0);
        wr(A_CTRL, 32'h800);
        rc(A_SRAM, 32'h5a5a0001);
        wr(A_PRESC, 32'h0);
        // a stray pulse on an unselected source must not count
        for (int s = 0; s < 3; s++) begin
            wr(A_CTRL, s);
            wr(A_TIME, 32'h0);
            tk((s == 0) ? 1 : 0, 1);
            tk(s, (s == 2) ? 128 : 1);
            rc(A_TIME, 32'h1);
        end
        // back to the lse source before ticking it
        wr(A_CTRL, 32'h0);
        wr(A_PRESC, 32'h3);
        wr(A_TIME, 32'h0);
        rc(A_SSR, 32'h3);
        tk(0, 1);
        rc(A_SSR, 32'h2);
        wr(A_PRESC, 32'h0);
        for (int i = 0; i < 5; i++) begin
            wr(A_DATE, D_IN[i]);
            wr(A_TIME, 32'h00235959);
            tk(0, 1);
            rc(A_TIME, 32'h0);
            rc(A_DATE, D_OUT[i]);
        end
        wr(A_CTRL, 32'h40);
        for (int i = 0; i < 3; i++) begin
            wr(A_TIME, H_IN[i]);
            tk(0, 1);
            rc(A_TIME, H_OUT[i]);
        end
        // minutes target differs but is masked out, so only seconds decide
        for (int i = 0; i < NALRM; i++) begin
            // move off the target first, or a match left from the last pass fires early
            wr(A_TIME, 32'h4);
            wr(A_CTRL, 32'h10 << i);
            wr(A_ALRM + A_ALRM_STEP * 13'(i), 32'h80808705);
            wr(A_ALRM + A_ALRM_STEP * 13'(i) + A_ALSS_OFS, 32'h80000000);
            wr(A_MASK, 32'h1 << i);
            rc(A_STAT, 32'h0);
            tk(0, 1);
            rc(A_STAT, 32'h1 << i);
            check({31'h0, irq}, 32'h1);
            check({31'h0, wake}, 32'h1);
            wr(A_STAT, 32'h3);
            rc(A_STAT, 32'h0);
        end
        wr(A_MASK, 32'h4);
        wr(A_WUT, 32'h1);
        wr(A_CTRL, 32'h408);
        tk(0, 1);
        rc(A_STAT, 32'h4);
        check({31'h0, irq}, 32'h1);
        wr(A_MASK, 32'h0);
        rc(A_MASK, 32'h0);
        check({31'h0, irq}, 32'h0);
        check({31'h0, wake}, 32'h1);
        wr(A_STAT, 32'h4);
        tk(0, 1);
        rc(A_STAT, 32'h0);
        tk(0, 1);
        rc(A_STAT, 32'h4);
        // sixteen ticks hold exactly one divide-by-16 wakeup clock; reload 0 flags on each
        wr(A_WUT, 32'h0);
        wr(A_CTRL, 32'h008);
        wr(A_STAT, 32'h4);
        tk(0, 16);
        rc(A_STAT, 32'h4);
        // extended 1 hz range reloads 0x10000, so no flag within two seconds
        wr(A_CTRL, 32'h508);
        wr(A_STAT, 32'h4);
        tk(0, 2);
        rc(A_STAT, 32'h0);
        wr(A_CTRL, 32'h4);
        // divider phase runs free, so align on the first rise
        for (int n = 0; n < 32 && !cal_out; n++) tk(0, 1);
        check({31'h0, cal_out}, 32'h1);
        tk(0, 31);
        check({31'h0, cal_out}, 32'h1);
        tk(0, 1);
        check({31'h0, cal_out}, 32'h0);
        summarize();
    end
endmodule

/* File: rtcb_pkg.sv */
// constants, register map and mode encodings of the backup-domain rtc
// assumes one 50 MHz clock; source clocks arrive as one-cycle ticks
package rtcb_pkg;
    localparam int ADDR_W     = 13;
    localparam int NBKP       = 20;
    localparam int SRAM_WORDS = 1024;
    localparam int SRAM_IW    = 10;
    localparam int NALRM      = 2;
    localparam int NEV        = 3;
    localparam int CTRL_W     = 12;

    // byte offsets, word aligned
    localparam logic [12:0] A_TIME      = 13'h0000;
    localparam logic [12:0] A_DATE      = 13'h0004;
    localparam logic [12:0] A_CTRL      = 13'h0008;
    localparam logic [12:0] A_PRESC     = 13'h000c;
    localparam logic [12:0] A_WUT       = 13'h0010;
    localparam logic [12:0] A_SSR       = 13'h0014;
    localparam logic [12:0] A_STAT      = 13'h0018;
    localparam logic [12:0] A_MASK      = 13'h001c;
    localparam logic [12:0] A_ALRM      = 13'h0020;
    localparam logic [12:0] A_ALRM_STEP = 13'h0008;
    localparam logic [12:0] A_ALSS_OFS  = 13'h0004;
    localparam logic [12:0] A_BKP       = 13'h0050;
    localparam logic [12:0] A_BKP_STEP  = 13'h0004;
    localparam logic [12:0] A_SRAM      = 13'h1000;

    // control bits
    localparam int C_CLKSEL = 0;
    localparam int C_CALEN  = 2;
    localparam int C_WUTEN  = 3;
    localparam int C_ALREN  = 4;
    localparam int C_FMT12  = 6;
    localparam int C_WUTSEL = 8;
    localparam int C_SRAMEN = 11;

    // status and mask bits
    localparam int S_ALR = 0;
    localparam int S_WUT = 2;

    // alarm word mask and weekday select bits
    localparam int AL_MSK_S = 7;
    localparam int AL_MSK_M = 15;
    localparam int AL_MSK_H = 23;
    localparam int AL_WDSEL = 30;
    localparam int AL_MSK_D = 31;
    localparam int SS_MSK   = 31;

    // reset values
    localparam logic [6:0]  PDA_RST  = 7'h7f;
    localparam logic [12:0] PDS_RST  = 13'h00ff;
    localparam logic [15:0] WUT_RST  = 16'hffff;

    // bcd limits
    localparam logic [7:0] BCD_ZERO   = 8'h00;
    localparam logic [7:0] SEC_MAX    = 8'h59;
    localparam logic [7:0] HR24_MAX   = 8'h23;
    localparam logic [7:0] HR12_MAX   = 8'h12;
    localparam logic [7:0] HR_PMFLIP  = 8'h11;
    localparam logic [7:0] DAY_MIN    = 8'h01;
    localparam logic [7:0] FEB_DAYS   = 8'h28;
    localparam logic [7:0] FEB_LEAP   = 8'h29;
    localparam logic [7:0] DAYS_SHORT = 8'h30;
    localparam logic [7:0] DAYS_LONG  = 8'h31;
    localparam logic [7:0] MON_MAX    = 8'h12;
    localparam logic [7:0] YEAR_MAX   = 8'h99;
    localparam logic [4:0] MON_FEB    = 5'h02;
    localparam logic [2:0] WDAY_MIN   = 3'h1;
    localparam logic [2:0] WDAY_MAX   = 3'h7;

    // timing counts in source ticks
    localparam logic [6:0] HSE_DIV_LAST = 7'h7f;
    localparam logic [4:0] CAL_LAST     = 5'h1f;

    typedef enum logic [1:0] {
        CS_LSE = 2'b00,
        CS_LSI = 2'b01,
        CS_HSE = 2'b10
    } rtcb_clksel_t;

    typedef enum logic [2:0] {
        WR_DIV16   = 3'b000,
        WR_DIV8    = 3'b001,
        WR_DIV4    = 3'b010,
        WR_DIV2    = 3'b011,
        WR_SEC     = 3'b100,
        WR_SEC_EXT = 3'b101
    } rtcb_wures_t;
endpackage
